// File: src/lup_port.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
module lup_port #(
  parameter int LINE_DIV = lup_pkg::LUP_LINE_DIV_DEF
) (
  // Clock and reset.
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [lup_pkg::LUP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [lup_pkg::LUP_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [lup_pkg::LUP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [lup_pkg::LUP_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // Outbound bit stream from the framer core.
  input  wire logic [lup_pkg::LUP_WORD_W-1:0] tx_bit_data,
  input  wire logic                           tx_bit_valid,
  output logic                                tx_bit_ready,
  // Line unit pins.
  output logic                                transmit_line_clock,
  output logic                                tx_line_positive,
  output logic                                tx_line_negative,
  input  wire logic                           external_signal_loss_in,
  // Loss of signal towards the framer core.
  output logic                                signal_loss_declared
);
  import lup_pkg::*;

  localparam int LEVEL_W = $clog2(LUP_FIFO_DEPTH) + 1;

  // Maps a byte address to a register index; bit 8 flags a misaligned or out of range address.
  function automatic logic [8:0] addr_to_idx(input logic [LUP_ADDR_W-1:0] a);
    logic bad;
    bad = (a[1:0] != 2'h0) || (a[LUP_ADDR_W-1:10] != '0);
    return {bad, a[9:2]};
  endfunction

  // True when an index names a register of this block.
  function automatic logic idx_mapped(input logic [8:0] i);
    return !i[8] && (i[7:0] == LUP_IDX_CTRL || i[7:0] == LUP_IDX_SCAN || i[7:0] == LUP_IDX_STAT);
  endfunction

  logic [2:0]                ctrl_q;
  logic                      underrun_q;
  logic                      los_q;
  logic [LEVEL_W-1:0]        level;
  logic                      aw_held_q;
  logic                      w_held_q;
  logic [LUP_ADDR_W-1:0]     awaddr_q;
  logic [LUP_DATA_W-1:0]     wdata_q;
  logic [3:0]                wstrb_q;
  logic                      wr_fire;
  logic [8:0]                wr_idx;
  logic                      rd_fire;
  logic [8:0]                rd_idx;
  logic [7:0]                div_q;
  logic                      half_tick;
  logic                      bit_en;
  logic                      line_clk_q;
  logic                      pos_q;
  logic                      neg_q;
  logic                      bipolar;
  logic                      ul_clear;

  lup_stream_if #(.WIDTH(LUP_WORD_W)) fill_if ();
  lup_stream_if #(.WIDTH(LUP_WORD_W)) drain_if ();

  // The four-word FIFO absorbs core jitter against the slower line bit rate.
  assign fill_if.valid = tx_bit_valid;
  assign fill_if.data  = tx_bit_data;
  assign tx_bit_ready  = fill_if.ready;

  lup_fifo #(
    .WIDTH (LUP_WORD_W),
    .DEPTH (LUP_FIFO_DEPTH)
  ) i_lup_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fill    (fill_if),
    .drain   (drain_if),
    .level   (level)
  );

  assign bipolar = ctrl_q[LUP_CTRL_BIPOLAR];

  // Write side: address and data are caught in either order and held until the response.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx        = addr_to_idx(awaddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; an unmapped address gets SLVERR and changes nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= LUP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= idx_mapped(wr_idx) ? LUP_RESP_OKAY : LUP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; only byte lane 0 carries fields.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= LUP_CTRL_RESET;
    end else if (wr_fire && !wr_idx[8] && wr_idx[7:0] == LUP_IDX_CTRL && wstrb_q[0]) begin
      ctrl_q <= wdata_q[2:0];
    end
  end

  // Read side: one read at a time, data registered with the response.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = addr_to_idx(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= LUP_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= idx_mapped(rd_idx) ? LUP_RESP_OKAY : LUP_RESP_SLVERR;
      s_axi_rdata  <= '0;
      if (!rd_idx[8]) begin
        unique case (rd_idx[7:0])
          LUP_IDX_CTRL: s_axi_rdata[2:0] <= ctrl_q;
          LUP_IDX_SCAN: s_axi_rdata[LUP_SCAN_LOS] <= external_signal_loss_in;
          LUP_IDX_STAT: begin
            s_axi_rdata[LUP_STAT_UNDERRUN] <= underrun_q;
            s_axi_rdata[LUP_STAT_LEVEL_LO +: LEVEL_W] <= level;
          end
          default: s_axi_rdata <= '0;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Loss of signal is trusted as a pure line-unit indication, never a spare input.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      los_q <= 1'b0;
    end else begin
      los_q <= external_signal_loss_in;
    end
  end
  assign signal_loss_declared = los_q;

  // Divider makes the transmit line clock; half_tick marks each of its edges.
  assign half_tick = (div_q == 8'(LINE_DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q      <= '0;
      line_clk_q <= 1'b0;
    end else if (half_tick) begin
      div_q      <= '0;
      line_clk_q <= !line_clk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign transmit_line_clock = line_clk_q;

  // A rising edge is a tick while the clock is low; falling while it is high.
  assign bit_en = half_tick && (ctrl_q[LUP_CTRL_FALLING] ? line_clk_q : !line_clk_q);

  // One word is drained per bit period while transmission is enabled.
  assign drain_if.ready = bit_en && ctrl_q[LUP_CTRL_TX_EN];

  // Line rails; an empty FIFO sends zeros so the line unit never sees a stale pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (bit_en) begin
      if (drain_if.valid && ctrl_q[LUP_CTRL_TX_EN]) begin
        pos_q <= drain_if.data[LUP_W_POS];
        neg_q <= drain_if.data[LUP_W_NEG];
      end else begin
        pos_q <= 1'b0;
        neg_q <= 1'b0;
      end
    end
  end
  assign tx_line_positive = pos_q;
  assign tx_line_negative = neg_q;

  // Underrun is sticky, cleared by writing one; a new underrun wins over the clear.
  assign ul_clear = wr_fire && !wr_idx[8] && wr_idx[7:0] == LUP_IDX_STAT &&
                    wstrb_q[0] && wdata_q[LUP_STAT_UNDERRUN];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underrun_q <= 1'b0;
    end else if (bit_en && ctrl_q[LUP_CTRL_TX_EN] && !drain_if.valid) begin
      underrun_q <= 1'b1;
    end else if (ul_clear) begin
      underrun_q <= 1'b0;
    end
  end

  // Checks sleep in reset; each rail is judged one cycle after the edge that moves it.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_uni_data;
    bit_en && drain_if.valid && drain_if.ready && !bipolar |=> tx_line_positive == $past(drain_if.data[0]);
  endproperty
  a_uni_data: assert property (p_uni_data) else $error("unipolar data not on positive rail");

  property p_pos_edge;
    $changed(tx_line_positive) |-> $past(bit_en);
  endproperty
  a_pos_edge: assert property (p_pos_edge) else $error("positive rail moved off the chosen edge");

  property p_rails_hold;
    !bit_en |=> $stable(tx_line_positive) && $stable(tx_line_negative);
  endproperty
  a_rails_hold: assert property (p_rails_hold) else $error("rails changed inside a bit period");

  property p_bip_pos;
    bit_en && drain_if.valid && drain_if.ready && bipolar |=> tx_line_positive == $past(drain_if.data[0]);
  endproperty
  a_bip_pos: assert property (p_bip_pos) else $error("positive pulse command lost");

  property p_scan_los;
    rd_fire && rd_idx == {1'b0, LUP_IDX_SCAN} |=> s_axi_rvalid && s_axi_rdata[0] == $past(external_signal_loss_in);
  endproperty
  a_scan_los: assert property (p_scan_los) else $error("scan bit does not show loss input");

  property p_los_declare;
    external_signal_loss_in |=> signal_loss_declared;
  endproperty
  a_los_declare: assert property (p_los_declare) else $error("loss of signal not declared");

  property p_uni_neg;
    bit_en && !bipolar && !(drain_if.valid && drain_if.ready) |=> !tx_line_negative;
  endproperty
  a_uni_neg: assert property (p_uni_neg) else $error("negative rail high without a frame end");

  property p_bip_neg;
    bit_en && drain_if.valid && drain_if.ready && bipolar |=> tx_line_negative == $past(drain_if.data[1]);
  endproperty
  a_bip_neg: assert property (p_bip_neg) else $error("negative pulse command lost");

  // A change of the edge choice may legally shorten one bit period, so that window is excused.
  property p_edge_period;
    bit_en && ctrl_q[LUP_CTRL_FALLING] == $past(ctrl_q[LUP_CTRL_FALLING], 3) |->
      !$past(bit_en) && !$past(bit_en, 2) && !$past(bit_en, 3);
  endproperty
  a_edge_period: assert property (p_edge_period) else $error("bit period shorter than line clock");

  property p_clk_edge;
    bit_en |=> transmit_line_clock == !$past(ctrl_q[LUP_CTRL_FALLING]);
  endproperty
  a_clk_edge: assert property (p_clk_edge) else $error("rails moved with the wrong clock edge");

  property p_rails_settle;
    $past(bit_en, 2) |-> $stable(tx_line_positive) && $stable(tx_line_negative);
  endproperty
  a_rails_settle: assert property (p_rails_settle) else $error("rails moved right after a bit edge");

  property p_neg_edge;
    $changed(tx_line_negative) |-> $past(bit_en);
  endproperty
  a_neg_edge: assert property (p_neg_edge) else $error("negative rail moved off the chosen edge");

  property p_uni_end;
    bit_en && !bipolar && drain_if.valid && drain_if.ready |=> tx_line_negative == $past(drain_if.data[LUP_W_NEG]);
  endproperty
  a_uni_end: assert property (p_uni_end) else $error("frame end pulse lost");

  // Quiet rails: with no word popped there is no pulse, so the line unit never repeats a stale bit.
  property p_uni_quiet;
    bit_en && !bipolar && !(drain_if.valid && drain_if.ready) |=> !tx_line_positive;
  endproperty
  a_uni_quiet: assert property (p_uni_quiet) else $error("positive rail high without data");

  property p_bip_quiet;
    bit_en && bipolar && !(drain_if.valid && drain_if.ready) |=> !tx_line_positive && !tx_line_negative;
  endproperty
  a_bip_quiet: assert property (p_bip_quiet) else $error("pulse commanded without a word");

  property p_off_quiet;
    bit_en && !ctrl_q[LUP_CTRL_TX_EN] |=> !tx_line_positive && !tx_line_negative;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("rails active while transmit is off");

  // Loss flag follows the pin both ways; a scan read is OKAY and zero above bit 0.
  property p_los_clear;
    !external_signal_loss_in |=> !signal_loss_declared;
  endproperty
  a_los_clear: assert property (p_los_clear) else $error("loss of signal held without input");

  property p_scan_upper;
    rd_fire && rd_idx == {1'b0, LUP_IDX_SCAN} |=>
      s_axi_rresp == LUP_RESP_OKAY && s_axi_rdata[LUP_DATA_W-1:1] == '0;
  endproperty
  a_scan_upper: assert property (p_scan_upper) else $error("scan register read not clean");
endmodule // lup_port

// File: src/lup_pkg.sv
package lup_pkg;
  // Register bus geometry.
  localparam int          LUP_ADDR_W   = 12;
  localparam int          LUP_DATA_W   = 32;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  LUP_IDX_CTRL = 8'h80;
  localparam logic [7:0]  LUP_IDX_SCAN = 8'h81;
  localparam logic [7:0]  LUP_IDX_STAT = 8'h82;
  // Control register fields.
  localparam int          LUP_CTRL_BIPOLAR = 0;
  localparam int          LUP_CTRL_FALLING = 1;
  localparam int          LUP_CTRL_TX_EN   = 2;
  localparam logic [2:0]  LUP_CTRL_RESET   = 3'h0;
  // Line interface scan register field.
  localparam int          LUP_SCAN_LOS     = 0;
  // Status register fields.
  localparam int          LUP_STAT_UNDERRUN = 0;
  localparam int          LUP_STAT_LEVEL_LO = 8;
  // Stream word fields: bit 0 positive rail or data, bit 1 negative rail or frame end.
  localparam int          LUP_WORD_W   = 2;
  localparam int          LUP_W_POS    = 0;
  localparam int          LUP_W_NEG    = 1;
  localparam int          LUP_FIFO_DEPTH = 4;
  // Half period of the transmit line clock, in aclk cycles.
  localparam int          LUP_LINE_DIV_DEF = 2;
  // Bus responses.
  localparam logic [1:0]  LUP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  LUP_RESP_SLVERR = 2'h2;
endpackage

// File: src/lup_stream_if.sv
interface lup_stream_if #(parameter int WIDTH = 2);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: src/lup_fifo.sv
module lup_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Filling and draining sides.
  lup_stream_if.snk              fill,
  lup_stream_if.src              drain,
  // Fill level for status.
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Honest flags: full stalls the source, empty withholds valid.
  assign fill.ready  = (cnt_q != (PW+1)'(DEPTH));
  assign drain.valid = (cnt_q != '0);
  assign drain.data  = mem_q[rd_q];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;
  assign level       = cnt_q;

  // Storage is written only on a push, so no reset is needed for it.
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= fill.data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // lup_fifo

// File: sim/lup_liu_model.sv
module lup_liu_model (
  // Clock.
  input  wire logic       aclk,
  // Loss request from the bench and the detector lag in cycles.
  input  wire logic       loss_cmd,
  input  wire logic [1:0] lag,
  // Loss level towards the port.
  output logic            external_signal_loss_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hist_q = 4'h0;

  // A slow detector reports late, so the port must follow the level whenever it settles.
  always_ff @(posedge aclk) begin
    hist_q <= {hist_q[2:0], loss_cmd};
  end

  // High only while loss is declared, low otherwise; the pin serves no other purpose.
  assign external_signal_loss_in = (lag == 2'h0) ? loss_cmd : hist_q[lag - 2'h1];
endmodule // lup_liu_model

// File: sim/line_unit_port_and_loss_input_test.sv
module line_unit_port_and_loss_input_test;
  timeunit 1ns;
  timeprecision 1ps;
  import lup_pkg::*;
  localparam logic [11:0] A_CTRL = {2'b00, LUP_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_SCAN = {2'b00, LUP_IDX_SCAN, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, LUP_IDX_STAT, 2'b00};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_bit_valid, tx_bit_ready, loss_cmd;
  logic        transmit_line_clock, tx_line_positive, tx_line_negative, external_signal_loss_in, signal_loss_declared;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, v;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  mode;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tx_bit_data, resp, lag, rails, rails_q, hist;
  logic        lc_q, sel, fall_sel, ok;
  logic [1:0]  exp_q[$];
  logic [31:0] lfsr_q = 32'h86b8_5b73;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          filled;

  lup_port #(.LINE_DIV(LUP_LINE_DIV_DEF)) i_lup_port (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_bit_data, .tx_bit_valid, .tx_bit_ready,
    .transmit_line_clock, .tx_line_positive, .tx_line_negative, .external_signal_loss_in, .signal_loss_declared
  );
  lup_liu_model i_lup_liu_model (.aclk, .loss_cmd, .lag, .external_signal_loss_in);

  // Free running 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  assign rails = {tx_line_negative, tx_line_positive};

  // Verdict and the single exit of the run.
  task automatic print_verdict;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("ERROR %0t mismatch seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic timeout;
    n_mismatch++;
    $display("ERROR %0t wait ran out", $time);
    print_verdict;
  endtask

  // Pseudo random source; the fixed start keeps every run identical.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rnd(output logic [31:0] r);
    lfsr_q = lfsr_next(lfsr_q);
    r = lfsr_q;
  endtask

  // A bipolar bit never asks for both pulses, and a zero word would hide among underrun bits.
  function automatic logic [1:0] word_for(input logic bip, input logic [31:0] r);
    return bip ? {r[0], ~r[0]} : ((r[1:0] == 2'b00) ? 2'b01 : r[1:0]);
  endfunction

  function automatic logic [33:0] stat_exp(input logic under, input logic [2:0] lvl);
    return {LUP_RESP_OKAY, 21'h0, lvl, 7'h0, under};
  endfunction

  // Write with address and data offered together, each dropped once taken.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    if (n == 64) timeout;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 64) timeout;
  endtask

  // Holds the current offer until an edge sees ready high.
  task automatic wait_taken(input int tries, output logic got);
    got = 1'b0;
    repeat (tries) begin
      @(posedge aclk);
      if (tx_bit_ready === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  // Line watcher: records every stream transfer, then expects them on the rails in order.
  always @(posedge aclk) begin
    if (aresetn) begin
      sel = fall_sel ? (lc_q & ~transmit_line_clock) : (~lc_q & transmit_line_clock);
      if (rails !== rails_q && !(sel || hist[0])) check({32'h0, rails}, {32'h0, rails_q});
      if (hist[1] && rails != 2'b00) begin
        if (exp_q.size() == 0) check({32'h0, rails}, 34'h0);
        else check({32'h0, rails}, {32'h0, exp_q.pop_front()});
      end
      hist = {hist[0], sel};
    end
    lc_q = transmit_line_clock;
    rails_q = rails;
    if (aresetn && tx_bit_valid && tx_bit_ready) exp_q.push_back(tx_bit_data);
  end

  // Main sequence.
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tx_bit_valid, loss_cmd, fall_sel, lc_q} = 7'h00;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_bit_data, lag, hist, rails_q} = 64'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(A_CTRL, rd, resp);
    check({resp, rd}, {LUP_RESP_OKAY, 32'h0});
    axi_rd(12'h3fc, rd, resp);
    check({resp, rd}, {LUP_RESP_SLVERR, 32'h0});
    axi_wr(12'h201, 32'h0000_0007, resp);
    check({resp, 32'h0}, {LUP_RESP_SLVERR, 32'h0});
    axi_wr(A_SCAN, 32'h0000_0001, resp);
    check({resp, 32'h0}, {LUP_RESP_OKAY, 32'h0});
    for (int k = 0; k < 6; k++) begin
      rnd(v);
      loss_cmd <= k[0];
      lag <= v[1:0];
      repeat (6) @(posedge aclk);
      axi_rd(A_SCAN, rd, resp);
      check({resp, rd}, {LUP_RESP_OKAY, 31'h0, loss_cmd});
      check({33'h0, signal_loss_declared}, {33'h0, loss_cmd});
    end
    for (int m = 0; m < 3; m++) begin
      mode = (m == 0) ? 3'h0 : ((m == 1) ? 3'h1 : 3'h3);
      fall_sel <= mode[1];
      axi_wr(A_CTRL, {29'h0, mode}, resp);
      filled = 0;
      for (int i = 0; i < 6; i++) begin
        rnd(v);
        tx_bit_data <= word_for(mode[0], v);
        tx_bit_valid <= 1'b1;
        wait_taken(4, ok);
        if (!ok) break;
        filled++;
      end
      check({2'b00, 32'(filled)}, {2'b00, 32'(LUP_FIFO_DEPTH)});
      axi_rd(A_STAT, rd, resp);
      check({resp, rd}, stat_exp(1'b0, 3'(LUP_FIFO_DEPTH)));
      axi_wr(A_CTRL, {29'h0, mode | 3'h4}, resp);
      wait_taken(64, ok);
      if (!ok) timeout;
      repeat (12) begin
        rnd(v);
        tx_bit_data <= word_for(mode[0], v);
        wait_taken(64, ok);
        if (!ok) timeout;
      end
      tx_bit_valid <= 1'b0;
      for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge aclk);
      if (exp_q.size() > 0) timeout;
      repeat (12) @(posedge aclk);
      axi_rd(A_STAT, rd, resp);
      check({resp, rd}, stat_exp(1'b1, 3'h0));
      axi_wr(A_CTRL, {29'h0, mode}, resp);
      axi_wr(A_STAT, 32'h0000_0001, resp);
      axi_rd(A_STAT, rd, resp);
      check({resp, rd}, stat_exp(1'b0, 3'h0));
    end
    print_verdict;
  end
endmodule // line_unit_port_and_loss_input_test
